// ===== irq_flags_pkg.sv
package irq_flags_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_FLAG = 8'h00;
    localparam logic [7:0] OFS_UPPER_MASK = 8'h04;
    localparam logic [7:0] OFS_LOWER_MASK = 8'h08;
    localparam logic [7:0] OFS_GEN_CTRL = 8'h0C;
    localparam logic [7:0] OFS_SENSE = 8'h10;

    // source indices; a flag sits at FLAG_LSB plus its index
    localparam int NUM_SRC = 5;
    localparam int SRC_LO = 0;
    localparam int SRC_UP = 1;
    localparam int SRC_C = 2;
    localparam int SRC_A = 3;
    localparam int SRC_B = 4;
    localparam int FLAG_LSB = 3;

    // pins per pin-change group
    localparam int GROUP_PINS = 8;

    // reset values
    localparam logic [NUM_SRC-1:0] FLAG_RST = 5'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] GEN_CTRL_RST = 8'h00;
    localparam logic [7:0] SENSE_RST = 8'h00;

    // two-bit sense codes for pins a and b
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_ANY = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    // general control: enables laid out like the flags, bits 7..3
    typedef struct packed {
        logic [NUM_SRC-1:0] en;
        logic [2:0] rsvd;
    } gen_ctrl_t;

    // sense control: bit 4 pin c edge, 3:2 pin b, 1:0 pin a
    typedef struct packed {
        logic [2:0] rsvd;
        logic c_rise;
        logic [1:0] b_sense;
        logic [1:0] a_sense;
    } sense_ctrl_t;

endpackage

// ===== sync_bits.sv
module sync_bits #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // asynchronous inputs and their synchronised copy
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_reg; // first stage, read only by second
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg; // second stage, safe to use
    logic [WIDTH-1:0] sync_next;

    // two-stage shift, nothing looks at the first stage
    always_comb begin
        meta_next = din;
        sync_next = meta_reg;
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign dout = sync_reg;

endmodule

// ===== pin_change_detect.sv
module pin_change_detect
    import irq_flags_pkg::*;
#(
    parameter int PINS = GROUP_PINS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // synchronised pins and their gating
    input wire logic [PINS-1:0] pins,
    input wire logic [PINS-1:0] mask,
    input wire logic group_en,
    input wire logic compat_mode,
    // any enabled pin differs from its last sample
    output logic change
);

    logic [PINS-1:0] prev_reg; // last sample of every pin
    logic [PINS-1:0] prev_next;

    // sample every clock so a re-enabled pin sees no stale edge
    always_comb begin
        prev_next = pins; // [RULE22]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= prev_next;
        end
    end

    // masks live in extended space, unusable in legacy mode
    assign change = (|((pins ^ prev_reg) & mask)) & group_en & ~compat_mode; // [RULE16] [RULE17] [RULE18] [RULE22]

    AST_PC_MASKED: assert property (@(posedge clk) disable iff (!rst_n)
        change |-> (|((pins ^ $past(pins)) & mask)) && group_en) // [RULE16]
        else $error("pin change raised without an enabled changed pin");

endmodule

// ===== ext_and_pin_change_irq_flags.sv
// What this block does
// (RULE1) pin b trigger sets flag bit 7
// (RULE2) pin b flag, enables give pin b request
// (RULE3) handler entry clears that source's flag
// (RULE4) write one clears flag, zero keeps it
// (RULE5) pin b low-level sense holds flag clear
// (RULE6) pin a trigger sets flag bit 6
// (RULE7) pin a flag, enables give pin a request
// (RULE8) pin a low-level sense holds flag clear
// (RULE9) pin c event sets flag bit 5
// (RULE10) pin c flag, enables give pin c request
// (RULE11) sleep buffer cutoff may set pin c flag
// (RULE12) upper group change sets flag bit 4
// (RULE13) upper flag, enables give upper request
// (RULE14) lower group change sets flag bit 3
// (RULE15) lower flag, enables give lower request
// (RULE16) upper mask bits gate their pins
// (RULE17) lower mask bits gate their pins
// (RULE18) no pin-change interrupts in legacy mode
// (RULE19) two-bit sense: low, any, fall, rise
// (RULE20) pin c sense bit: falling or rising edge
// (RULE21) pin activity counts even as output
// (RULE22) compare each enabled pin with last sample
//
// Added by the designer: the placing of the registers and the APB register port.
module ext_and_pin_change_irq_flags
    import irq_flags_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external interrupt pins, asynchronous
    input wire logic pin_a_input_and_enable,
    input wire logic pin_b_input_and_enable,
    input wire logic pin_c_input_and_enable,
    input wire logic [GROUP_PINS-1:0] upper_group_pins,
    input wire logic [GROUP_PINS-1:0] lower_group_pins,
    // processor core side, same clock
    input wire logic core_status_global_enable,
    input wire logic [NUM_SRC-1:0] core_ack,
    input wire logic sleep_active,
    input wire logic compat_mode,
    output logic [NUM_SRC-1:0] irq_req
);

    localparam int SYNC_W = 3 + 2 * GROUP_PINS;

    // register state
    logic [NUM_SRC-1:0] flag_reg; // sticky source flags
    logic [NUM_SRC-1:0] flag_next;
    logic [7:0] upper_mask_reg; // pinchg_upper_mask
    logic [7:0] upper_mask_next;
    logic [7:0] lower_mask_reg; // pinchg_lower_mask
    logic [7:0] lower_mask_next;
    gen_ctrl_t gen_ctrl_reg; // general_irq_control_reg
    gen_ctrl_t gen_ctrl_next;
    sense_ctrl_t sense_reg; // sense control fields
    sense_ctrl_t sense_next;

    // bus answer state
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;

    // request outputs and edge history
    logic [NUM_SRC-1:0] irq_req_reg;
    logic [NUM_SRC-1:0] irq_req_next;
    logic [2:0] ext_prev_reg; // {b, a, c} last samples
    logic [2:0] ext_prev_next;

    // synchronised pins
    logic [SYNC_W-1:0] raw_pins;
    logic [SYNC_W-1:0] sync_pins;
    logic pin_a_s;
    logic pin_b_s;
    logic pin_c_s;
    logic pin_c_int; // pin c after the sleep input gate
    logic [GROUP_PINS-1:0] upper_s;
    logic [GROUP_PINS-1:0] lower_s;

    // decode and events
    logic bus_setup;
    logic bus_access;
    logic flag_wr;
    logic [NUM_SRC-1:0] trig;
    logic up_change; // upper group detector output
    logic lo_change; // lower group detector output, kept apart so trig has one driver
    logic [NUM_SRC-1:0] level_req;
    logic [NUM_SRC-1:0] clr;

    // address hit; mask registers vanish in legacy mode
    function automatic logic reg_hit(input logic [7:0] addr, input logic compat);
        reg_hit = (addr == OFS_FLAG) || (addr == OFS_GEN_CTRL) || (addr == OFS_SENSE) ||
                  (!compat && ((addr == OFS_UPPER_MASK) || (addr == OFS_LOWER_MASK)));
    endfunction

    // two-bit sense decode shared by pins a and b
    function automatic logic ext_trigger(input logic [1:0] mode, input logic cur,
                                         input logic prev);
        unique case (mode)
            SENSE_LOW: ext_trigger = 1'b0; // level never sets the flag
            SENSE_ANY: ext_trigger = cur ^ prev;
            SENSE_FALL: ext_trigger = prev & ~cur;
            SENSE_RISE: ext_trigger = cur & ~prev;
        endcase
    endfunction

    // every pin is synchronised before any detection logic
    assign raw_pins = {pin_b_input_and_enable, pin_a_input_and_enable,
                       pin_c_input_and_enable, upper_group_pins, lower_group_pins};

    sync_bits #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .din(raw_pins),
        .dout(sync_pins)
    );

    // pad level is read regardless of pin direction
    assign pin_b_s = sync_pins[SYNC_W-1]; // [RULE21]
    assign pin_a_s = sync_pins[SYNC_W-2];
    assign pin_c_s = sync_pins[SYNC_W-3];
    assign upper_s = sync_pins[2*GROUP_PINS-1:GROUP_PINS];
    assign lower_s = sync_pins[GROUP_PINS-1:0];

    // disabled pin c buffer reads low in sleep, may fake a falling edge
    assign pin_c_int = (sleep_active && !gen_ctrl_reg.en[SRC_C]) ? 1'b0 : pin_c_s; // [RULE11]

    // pin-change groups
    pin_change_detect #(
        .PINS(GROUP_PINS)
    ) u_upper (
        .clk(pclk),
        .rst_n(presetn),
        .pins(upper_s),
        .mask(upper_mask_reg),
        .group_en(gen_ctrl_reg.en[SRC_UP]),
        .compat_mode(compat_mode),
        .change(up_change)
    ); // [RULE16] [RULE18]

    pin_change_detect #(
        .PINS(GROUP_PINS)
    ) u_lower (
        .clk(pclk),
        .rst_n(presetn),
        .pins(lower_s),
        .mask(lower_mask_reg),
        .group_en(gen_ctrl_reg.en[SRC_LO]),
        .compat_mode(compat_mode),
        .change(lo_change)
    ); // [RULE17] [RULE18]

    // pin triggers: group changes, and pins a, b and c from sense settings
    always_comb begin
        trig[SRC_UP] = up_change; // [RULE12]
        trig[SRC_LO] = lo_change; // [RULE14]
        trig[SRC_B] = ext_trigger(sense_reg.b_sense, pin_b_s, ext_prev_reg[2]); // [RULE1] [RULE19]
        trig[SRC_A] = ext_trigger(sense_reg.a_sense, pin_a_s, ext_prev_reg[1]); // [RULE6] [RULE19]
        // pin c: edge only, the sense bit picks which
        trig[SRC_C] = sense_reg.c_rise ? (pin_c_int & ~ext_prev_reg[0]) :
                                         (ext_prev_reg[0] & ~pin_c_int); // [RULE9] [RULE20]
        ext_prev_next = {pin_b_s, pin_a_s, pin_c_int};
    end

    // low level requests straight from the pin, not from a flag
    always_comb begin
        level_req = '0;
        level_req[SRC_B] = (sense_reg.b_sense == SENSE_LOW) & ~pin_b_s;
        level_req[SRC_A] = (sense_reg.a_sense == SENSE_LOW) & ~pin_a_s;
    end

    // apb phase decode; the master holds the request through access
    assign bus_setup = psel & ~penable;
    assign bus_access = psel & penable & pready_reg;
    assign flag_wr = bus_access & pwrite & (paddr == OFS_FLAG);

    // flag next state; a new event wins over any clear
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            clr[i] = core_ack[i] | (flag_wr & pwdata[FLAG_LSB+i]); // [RULE3] [RULE4]
            flag_next[i] = trig[i] | (flag_reg[i] & ~clr[i]); // [RULE1] [RULE6] [RULE9] [RULE12] [RULE14]
        end
        // level sensing keeps the flag cleared
        if (sense_reg.b_sense == SENSE_LOW) begin
            flag_next[SRC_B] = 1'b0; // [RULE5]
        end
        if (sense_reg.a_sense == SENSE_LOW) begin
            flag_next[SRC_A] = 1'b0; // [RULE8]
        end
    end

    // vector requests need global enable, source enable and flag or low level
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            irq_req_next[i] = core_status_global_enable & gen_ctrl_reg.en[i] &
                              (flag_reg[i] | level_req[i]); // [RULE2] [RULE7] [RULE10] [RULE13] [RULE15]
        end
    end

    // control register writes land at the access edge only
    always_comb begin
        upper_mask_next = upper_mask_reg;
        lower_mask_next = lower_mask_reg;
        gen_ctrl_next = gen_ctrl_reg;
        sense_next = sense_reg;
        if (bus_access && pwrite && reg_hit(paddr, compat_mode)) begin
            unique case (paddr)
                OFS_UPPER_MASK: upper_mask_next = pwdata[7:0];
                OFS_LOWER_MASK: lower_mask_next = pwdata[7:0];
                OFS_GEN_CTRL: gen_ctrl_next = gen_ctrl_t'({pwdata[7:FLAG_LSB], 3'h0});
                OFS_SENSE: sense_next = sense_ctrl_t'({3'h0, pwdata[4:0]});
                default: ; // flag register handled above
            endcase
        end
    end

    // answer prepared at the setup edge so all outputs are registered
    always_comb begin
        pready_next = bus_setup;
        pslverr_next = bus_setup & ~reg_hit(paddr, compat_mode);
        prdata_next = 32'h0000_0000;
        if (bus_setup && !pwrite) begin
            // unmapped and legacy-hidden offsets read zero
            unique case (paddr)
                OFS_FLAG: prdata_next[7:0] = {flag_reg, 3'h0};
                OFS_UPPER_MASK: prdata_next[7:0] = compat_mode ? 8'h00 : upper_mask_reg;
                OFS_LOWER_MASK: prdata_next[7:0] = compat_mode ? 8'h00 : lower_mask_reg;
                OFS_GEN_CTRL: prdata_next[7:0] = gen_ctrl_reg;
                OFS_SENSE: prdata_next[7:0] = sense_reg;
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    // all state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= FLAG_RST;
            upper_mask_reg <= MASK_RST;
            lower_mask_reg <= MASK_RST;
            gen_ctrl_reg <= gen_ctrl_t'(GEN_CTRL_RST);
            sense_reg <= sense_ctrl_t'(SENSE_RST);
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_req_reg <= '0;
            ext_prev_reg <= 3'h0;
        end else begin
            flag_reg <= flag_next;
            upper_mask_reg <= upper_mask_next;
            lower_mask_reg <= lower_mask_next;
            gen_ctrl_reg <= gen_ctrl_next;
            sense_reg <= sense_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_req_reg <= irq_req_next;
            ext_prev_reg <= ext_prev_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq_req = irq_req_reg;

    // checks, one clock domain
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_B_SET: assert property (trig[SRC_B] |=> flag_reg[SRC_B] || // [RULE1]
        $past(sense_reg.b_sense) == SENSE_LOW) else $error("pin b event lost");

    AST_B_REQ: assert property (core_status_global_enable && gen_ctrl_reg.en[SRC_B] && // [RULE2]
        flag_reg[SRC_B] |=> irq_req[SRC_B]) else $error("pin b request missing");

    AST_ACK_CLR: assert property (core_ack[SRC_UP] && !trig[SRC_UP] |=> // [RULE3]
        !flag_reg[SRC_UP]) else $error("ack did not clear upper flag");

    AST_W1C: assert property (flag_wr && pwdata[FLAG_LSB+SRC_C] && !trig[SRC_C] |=> // [RULE4]
        !flag_reg[SRC_C]) else $error("write one did not clear pin c flag");

    AST_W0_KEEP: assert property (flag_wr && !pwdata[FLAG_LSB+SRC_LO] && flag_reg[SRC_LO] && // [RULE4]
        !core_ack[SRC_LO] |=> flag_reg[SRC_LO]) else $error("write zero changed lower flag");

    AST_B_LEVEL: assert property (sense_reg.b_sense == SENSE_LOW && // [RULE5]
        $past(sense_reg.b_sense) == SENSE_LOW |-> !flag_reg[SRC_B])
        else $error("pin b flag set in level mode");

    AST_A_SET: assert property (sense_reg.a_sense == SENSE_FALL && ext_prev_reg[1] && // [RULE6]
        !pin_a_s |=> flag_reg[SRC_A]) else $error("pin a falling edge lost");

    AST_A_REQ: assert property (irq_req[SRC_A] |-> $past(core_status_global_enable) && // [RULE7]
        $past(gen_ctrl_reg.en[SRC_A])) else $error("pin a request without enables");

    AST_A_LEVEL: assert property (sense_reg.a_sense == SENSE_LOW && // [RULE8]
        $past(sense_reg.a_sense) == SENSE_LOW |-> !flag_reg[SRC_A])
        else $error("pin a flag set in level mode");

    AST_C_SET: assert property (sense_reg.c_rise && pin_c_int && !ext_prev_reg[0] |=> // [RULE9]
        flag_reg[SRC_C]) else $error("pin c rising edge lost");

    AST_C_REQ: assert property (!core_status_global_enable |=> !irq_req[SRC_C]) // [RULE10]
        else $error("pin c request with global enable off");

    AST_C_SLEEP: assert property (sleep_active && !gen_ctrl_reg.en[SRC_C] |-> !pin_c_int) // [RULE11]
        else $error("pin c buffer not gated in sleep");

    AST_UP_SET: assert property (trig[SRC_UP] |=> flag_reg[SRC_UP]) // [RULE12]
        else $error("upper group change lost");

    AST_UP_REQ: assert property (flag_reg[SRC_UP] && gen_ctrl_reg.en[SRC_UP] && // [RULE13]
        core_status_global_enable |=> irq_req[SRC_UP]) else $error("upper request missing");

    AST_LO_SET: assert property (trig[SRC_LO] |=> flag_reg[SRC_LO]) // [RULE14]
        else $error("lower group change lost");

    AST_LO_REQ: assert property (!gen_ctrl_reg.en[SRC_LO] |=> !irq_req[SRC_LO]) // [RULE15]
        else $error("lower request while disabled");

    AST_LO_MASK: assert property (lower_mask_reg == 8'h00 |-> !trig[SRC_LO]) // [RULE17]
        else $error("lower change with all pins masked");

    AST_COMPAT: assert property (compat_mode |-> !trig[SRC_UP] && !trig[SRC_LO]) // [RULE18]
        else $error("pin change in legacy mode");

    AST_C_FALL: assert property (!sense_reg.c_rise && pin_c_int && !ext_prev_reg[0] |-> // [RULE20]
        !trig[SRC_C]) else $error("pin c rise taken in falling mode");

    AST_APB_ANS: assert property (bus_setup |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

    COV_B_REQ: cover property (trig[SRC_B] ##1 flag_reg[SRC_B] ##1 irq_req[SRC_B]);
    COV_SLEEP_C: cover property (sleep_active && trig[SRC_C]);
    COV_SET_CLR: cover property (trig[SRC_UP] && core_ack[SRC_UP]);
    COV_W1C: cover property (flag_wr && |flag_reg);

endmodule

// ===== core_model.sv
module core_model
    import irq_flags_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // vector requests and how promptly the core serves them
    input wire logic [NUM_SRC-1:0] irq_req,
    input wire logic serve,
    input wire logic [3:0] latency,
    // handler entry, one-hot pulse
    output logic [NUM_SRC-1:0] core_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg; // cycles the pending request has waited
    logic [NUM_SRC-1:0] pick; // highest pending source
    // last set bit wins, so the highest index goes first
    always_comb begin
        pick = '0;
        for (int k = 0; k < NUM_SRC; k++) begin
            if (irq_req[k]) begin
                pick = '0;
                pick[k] = 1'b1;
            end
        end
    end
    // a request falls two edges after its ack, so latency below 2 would ack twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 4'h0;
            core_ack <= '0;
        end else if (serve && irq_req != '0 && cnt_reg >= latency) begin
            cnt_reg <= 4'h0;
            core_ack <= pick;
        end else begin
            cnt_reg <= (serve && irq_req != '0) ? cnt_reg + 4'h1 : 4'h0;
            core_ack <= '0;
        end
    end
endmodule

// ===== tb_top.sv
module tb_top
    import irq_flags_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and apb master
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    // pins and core side
    logic pa, pb, pc, gie, sleep_active, compat_mode, serve;
    logic [7:0] up, lo;
    logic [NUM_SRC-1:0] core_ack, irq_req;
    logic [3:0] latency;
    // bench state
    int seed, miscompares, comparisons, i, n;
    logic [1:0] s;
    logic [7:0] ctrl, um, lm, nu, nl;
    logic na, nb, nc, crise, err;
    logic [4:0] ef, er, seen;
    logic [31:0] rd;

    ext_and_pin_change_irq_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_a_input_and_enable(pa), .pin_b_input_and_enable(pb),
        .pin_c_input_and_enable(pc), .upper_group_pins(up), .lower_group_pins(lo),
        .core_status_global_enable(gie), .core_ack(core_ack),
        .sleep_active(sleep_active), .compat_mode(compat_mode), .irq_req(irq_req));
    core_model core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .serve(serve),
        .latency(latency), .core_ack(core_ack));

    // 40 MHz system clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        comparisons++;
        if (seen_v !== exp_v) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge pclk);
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so the next call never re-drives psel in this time step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        check(rd, e);
        check({31'h0, err}, {31'h0, ee});
    endtask

    // does this sense code fire on the old to new transition
    function automatic logic trig(input logic [1:0] c, input logic o, input logic v);
        case (c)
            SENSE_ANY: return o ^ v;
            SENSE_FALL: return o & ~v;
            SENSE_RISE: return ~o & v;
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        seed = 21;
        miscompares = 0;
        comparisons = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pa, pb, pc, up, lo, gie, sleep_active, compat_mode, serve} = '0;
        latency = 4'h2;
        tick(4);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, then an unmapped word
        for (i = 0; i < 5; i++) rchk(8'(i * 4), 32'h0, 1'b0);
        rchk(8'h14, 32'h0, 1'b1);
        $display("test reset done");
        // every sense code first, then random ones; group pins rest at 0 while reconfiguring
        for (i = 0; i < 24; i++) begin
            s = (i < 8) ? 2'(i) : 2'($random(seed));
            ctrl = 8'($random(seed)) & 8'hF8;
            um = 8'($random(seed));
            lm = 8'($random(seed));
            crise = 1'($random(seed));
            up <= 8'h00;
            lo <= 8'h00;
            tick(6);
            wr(OFS_SENSE, {3'h0, crise, s, s});
            wr(OFS_GEN_CTRL, ctrl);
            wr(OFS_UPPER_MASK, um);
            wr(OFS_LOWER_MASK, lm);
            wr(OFS_FLAG, 8'hF8);
            {na, nb, nc, nu, nl} = 19'($random(seed));
            ef = {trig(s, pb, nb), trig(s, pa, na), trig({1'b1, crise}, pc, nc),
                  |(nu & um) & ctrl[4], |(nl & lm) & ctrl[3]};
            pa <= na;
            pb <= nb;
            pc <= nc;
            up <= nu;
            lo <= nl;
            gie <= 1'($random(seed));
            tick(6);
            rchk(OFS_FLAG, {24'h0, ef, 3'h0}, 1'b0);
            er = ef & ctrl[7:3] & {5{gie}};
            if (s == SENSE_LOW) begin
                er[SRC_A] = gie & ctrl[6] & ~pa;
                er[SRC_B] = gie & ctrl[7] & ~pb;
            end
            check(32'(irq_req), 32'(er));
            // ones clear the pin a and b flags, zeros keep the rest
            wr(OFS_FLAG, 8'hC0);
            rchk(OFS_FLAG, {24'h0, ef & 5'h07, 3'h0}, 1'b0);
        end
        $display("test sense and groups done");
        // legacy mode hides the masks and silences both groups
        wr(OFS_UPPER_MASK, 8'hFF);
        wr(OFS_LOWER_MASK, 8'hFF);
        wr(OFS_GEN_CTRL, 8'hF8);
        compat_mode <= 1'b1;
        tick(2);
        wr(OFS_FLAG, 8'hF8);
        rchk(OFS_UPPER_MASK, 32'h0, 1'b1);
        up <= ~up;
        lo <= ~lo;
        tick(6);
        rchk(OFS_FLAG, 32'h0, 1'b0);
        $display("test legacy mode done");
        // every source raised at once, the core model serves each in turn
        compat_mode <= 1'b0;
        gie <= 1'b1;
        serve <= 1'b1;
        latency <= 4'(2 + ($random(seed) & 7));
        wr(OFS_SENSE, {3'h0, ~pc, SENSE_ANY, SENSE_ANY});
        pa <= ~pa;
        pb <= ~pb;
        pc <= ~pc;
        up <= ~up;
        lo <= ~lo;
        n = 0;
        seen = '0;
        while ((n < 6 || irq_req !== 5'h00) && n < 300) begin
            seen |= irq_req;
            n++;
            @(posedge pclk);
        end
        if (n == 300) begin
            miscompares++;
            print_verdict();
        end
        check(32'(seen), 32'h1F);
        rchk(OFS_FLAG, 32'h0, 1'b0);
        $display("test handler entry done");
        // sleep with pin c disabled may set its flag but must not request
        serve <= 1'b0;
        pc <= 1'b1;
        wr(OFS_SENSE, {3'h0, 1'b0, SENSE_ANY, SENSE_ANY});
        wr(OFS_GEN_CTRL, 8'hD8);
        tick(4);
        wr(OFS_FLAG, 8'hF8);
        // gated buffer reads low: a falling edge on the internal pin c
        sleep_active <= 1'b1;
        tick(6);
        rchk(OFS_FLAG, 32'h20, 1'b0);
        check(32'(irq_req[SRC_C]), 32'h0);
        $display("test sleep done");
        print_verdict();
    end
endmodule
